// ### mmucfg_regs.sv
`timescale 1ns/1ps
// Contract
// - upper nibble sets upper shared window start
// - upper nibble resets to all ones
// - lower nibble sets paged window start
// - lower nibble resets to all ones
// - 64 KB split into three regions
// - strobe enable bit, set on reset
// - enabled: strobe on fetch, level0, NMI first
// - enabled: return fetched once, fast cycles
// - disabled: no strobe on ordinary fetches
// - disabled: return refetched with strobe asserted
// - top two bits relocate internal I/O
// - decode only when upper address byte zero
// - relocation bits clear on reset
// - writing bit 5 one enters I/O halt
// - I/O halt leaves on zero write or reset
// - upper base adds, 20-bit, clears on reset
// - paged base adds, clears on reset
module mmucfg_regs
   import mmucfg_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   // Internal I/O port from the core
   input  wire logic [15:0] io_addr,
   input  wire logic [7:0]  io_wdata,
   input  wire logic        io_wr,
   input  wire logic        io_rd,
   output logic      [7:0]  io_rdata,
   output logic             io_hit,
   // Logical to physical translation
   input  wire logic [15:0] log_addr,
   output logic      [19:0] phys_addr,
   // Bus cycle kinds from the core sequencer
   input  wire logic        opcode_fetch,
   input  wire logic        level0_ack,
   input  wire logic        nmi_ack_first,
   input  wire logic        interrupt_return_opcode_fetched,
   input  wire logic        refetch_cycle,
   // Compatibility outputs
   output logic             fetch_cycle_strobe_n,
   output logic             interrupt_return_opcode_refetch_req,
   output logic             interrupt_return_opcode_fast_cycles,
   output logic             io_halt_mode
);

   // Stored register fields
   // All of them sit on the core clock and are written from logic on that clock,
   // so no input here needs a synchroniser
   logic [7:0] area_boundary_r;     // Upper nibble upper start, lower paged start
   logic [7:0] upper_base_r;        // Upper shared window base, 4 KB units
   logic [7:0] paged_base_r;        // Paged window base, 4 KB units
   logic       strobe_en_r;         // Fetch strobe enable
   logic [1:0] reloc_r;             // Internal I/O relocation
   logic       io_halt_r;           // I/O halt mode
   logic       refetch_r;           // Return refetch still owed to the core

   // Address decode of the internal I/O block
   // Pure combinational decode; the registered answer follows one cycle later
   logic       block_sel;           // Address falls in the relocated block
   logic [5:0] io_off;              // Offset within the block
   logic       wr_upper;
   logic       wr_paged;
   logic       wr_area;
   logic       wr_compat;
   logic       wr_ioctl;
   logic       reg_hit;             // One of our registers is addressed
   logic [7:0] rd_mux;

   // Upper byte must be zero and bits 7:6 match the relocation field
   // The relocation field also moves the block holding this very register, so software
   // has to use the new address from the access after the write
   // Only the low 256 I/O addresses can reach us; the four 64-byte slots are the
   // only places the block can sit
   assign block_sel = (io_addr[15:8] == 8'h00)
                      && (io_addr[7:6] == reloc_r);
   assign io_off    = io_addr[5:0];

   // Decoding is used for both write strobes and the hit flag
   // A function keeps the offset compare in one place for all of its users
   function automatic logic off_is(input logic [5:0] off, input logic [5:0] want);
      off_is = (off == want);
   endfunction

   // One write strobe per register; at most one of them is high
   assign wr_upper  = io_wr && block_sel && off_is(io_off, MMUCFG_OFF_UPPER_BASE);
   assign wr_paged  = io_wr && block_sel && off_is(io_off, MMUCFG_OFF_PAGED_BASE);
   assign wr_area   = io_wr && block_sel && off_is(io_off, MMUCFG_OFF_AREA_BOUND);
   assign wr_compat = io_wr && block_sel && off_is(io_off, MMUCFG_OFF_COMPAT);
   assign wr_ioctl  = io_wr && block_sel && off_is(io_off, MMUCFG_OFF_IO_CTRL);
   // Hit flag covers reads and writes of any of the five registers
   assign reg_hit   = block_sel && (off_is(io_off, MMUCFG_OFF_UPPER_BASE)
                      || off_is(io_off, MMUCFG_OFF_PAGED_BASE)
                      || off_is(io_off, MMUCFG_OFF_AREA_BOUND)
                      || off_is(io_off, MMUCFG_OFF_COMPAT)
                      || off_is(io_off, MMUCFG_OFF_IO_CTRL));

   // Read data; reserved bits read as zero, misses read zero
   // Zero on a miss keeps the shared read path quiet for other I/O blocks
   assign rd_mux =
      !block_sel                                     ? 8'h00 :
      off_is(io_off, MMUCFG_OFF_UPPER_BASE)          ? upper_base_r :
      off_is(io_off, MMUCFG_OFF_PAGED_BASE)          ? paged_base_r :
      off_is(io_off, MMUCFG_OFF_AREA_BOUND)          ? area_boundary_r :
      off_is(io_off, MMUCFG_OFF_COMPAT)              ? {strobe_en_r, 7'h00} :
      off_is(io_off, MMUCFG_OFF_IO_CTRL)             ? {reloc_r, io_halt_r, 5'h00} :
                                                       8'h00;

   // Area boundary register, both nibbles set to ones on reset
   // After reset only the top 4 KB page is upper shared and the rest is low shared,
   // so the core starts from a flat map
   always_ff @(posedge clk)
   begin
      if (rst)
         area_boundary_r <= MMUCFG_RST_AREA_BOUND;
      else if (wr_area)
         area_boundary_r <= io_wdata;
   end

   // Window bases, cleared on reset
   // Bases are whole 4 KB page numbers; the sum below spans 1 MB
   // A new base is used from the translation after the write
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         upper_base_r <= MMUCFG_RST_BASE;
         paged_base_r <= MMUCFG_RST_BASE;
      end
      else
      begin
         if (wr_upper)
            upper_base_r <= io_wdata;
         if (wr_paged)
            paged_base_r <= io_wdata;
      end
   end

   // Compatibility and I/O control fields
   // Only the defined bits are kept; writes to the reserved bits are dropped and
   // those bits read back as zero
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         strobe_en_r <= MMUCFG_RST_STROBE_EN;
         reloc_r     <= MMUCFG_RST_RELOC;
         io_halt_r   <= MMUCFG_RST_IO_HALT;
      end
      else
      begin
         if (wr_compat)
            strobe_en_r <= io_wdata[MMUCFG_POS_STROBE_EN];
         if (wr_ioctl)
         begin
            // Relocation takes effect from the next access, not this one
            reloc_r   <= {io_wdata[MMUCFG_POS_RELOC_HI], io_wdata[MMUCFG_POS_RELOC_LO]};
            io_halt_r <= io_wdata[MMUCFG_POS_IO_HALT];
         end
      end
   end

   // Region select on the 4 KB page number
   // Limitation: if software sets the paged start above the upper start the paged
   // window is empty; the upper window is tested first and wins
   logic [3:0]  page;
   logic        in_upper;
   logic        in_paged;
   logic [7:0]  sel_base;
   logic [19:0] phys_nxt;

   assign page     = log_addr[15:MMUCFG_PAGE_BITS];
   // Upper window from its start to the top, paged window below it
   assign in_upper = (page >= area_boundary_r[7:4]);
   assign in_paged = !in_upper && (page >= area_boundary_r[3:0]);
   // Low shared window uses a zero base
   assign sel_base = in_upper ? upper_base_r :
                     in_paged ? paged_base_r : 8'h00;
   // A 20-bit sum; carry out of the top wraps, as a 20-bit bus would
   assign phys_nxt = {4'h0, log_addr} + {sel_base, 12'h000};

   // Return refetch: owed after a return opcode fetch when the strobe is off
   // A new return fetch in the same cycle as the refetch wins, so a second request
   // is never lost to the clear
   logic refetch_nxt;
   assign refetch_nxt = (interrupt_return_opcode_fetched && !strobe_en_r) ? 1'b1 :
                        refetch_cycle                  ? 1'b0 : refetch_r;

   // Strobe: enabled cases, or the legacy refetch cycle
   // Registered, so the strobe trails its cause by one cycle; the core sequencer
   // allows for that when it lines the pin up with the bus cycle
   logic strobe_on;
   assign strobe_on = (strobe_en_r && (opcode_fetch || level0_ack || nmi_ack_first))
                      || (!strobe_en_r && refetch_cycle);

   // Registered outputs
   // Read data is forced to zero outside a read so that a stale value can never
   // look like a fresh answer
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         io_rdata             <= 8'h00;
         io_hit               <= 1'b0;
         phys_addr            <= 20'h00000;
         fetch_cycle_strobe_n <= 1'b1;
         refetch_r            <= 1'b0;
      end
      else
      begin
         io_rdata             <= io_rd ? rd_mux : 8'h00;
         io_hit               <= (io_rd || io_wr) && reg_hit;
         phys_addr            <= phys_nxt;
         fetch_cycle_strobe_n <= !strobe_on;
         refetch_r            <= refetch_nxt;
      end
   end

   // Mode outputs follow the register bits directly
   // These are flops already, so no extra stage is added
   assign interrupt_return_opcode_refetch_req = refetch_r;
   assign interrupt_return_opcode_fast_cycles = strobe_en_r;
   assign io_halt_mode     = io_halt_r;

   // Checks; each one but halt_write_a, which uses wr_ioctl, restates its rule from ports and stored
   // fields rather than from the decode wires above, so a slip in the decode shows up here
   // Boundary nibbles come up as all ones, so the core starts on a flat map
   area_reset_a: assert property (@(posedge clk)
      $fell(rst) |-> area_boundary_r == MMUCFG_RST_AREA_BOUND)
      else $error("area boundary not all ones after reset");
   area_nib_a: assert property (@(posedge clk) disable iff (rst)
      $past(rst) && !rst |-> area_boundary_r[7:4] == 4'hF && area_boundary_r[3:0] == 4'hF)
      else $error("area nibbles wrong after reset");
   // A write to the boundary register lands whole on the next edge
   area_write_a: assert property (@(posedge clk) disable iff (rst)
      io_wr && io_addr == {8'h00, reloc_r, MMUCFG_OFF_AREA_BOUND}
      |=> area_boundary_r == $past(io_wdata))
      else $error("area boundary write lost");
   // Translation is checked against the stored bases, one cycle late like phys_addr
   upper_map_a: assert property (@(posedge clk) disable iff (rst)
      page >= area_boundary_r[7:4]
      |=> phys_addr == {4'h0, $past(log_addr)} + {$past(upper_base_r), 12'h000})
      else $error("upper window base not used");
   // Between the two starts the paged base is added
   paged_map_a: assert property (@(posedge clk) disable iff (rst)
      page >= area_boundary_r[3:0] && page < area_boundary_r[7:4]
      |=> phys_addr == {4'h0, $past(log_addr)} + {$past(paged_base_r), 12'h000})
      else $error("paged window base not used");
   // Below both starts the address passes with a zero base
   low_map_a: assert property (@(posedge clk) disable iff (rst)
      (page < area_boundary_r[3:0]) && (page < area_boundary_r[7:4])
      |=> phys_addr == {4'h0, $past(log_addr)})
      else $error("low window not mapped directly");
   // Strobe cases while the enable bit is set
   strobe_on_a: assert property (@(posedge clk) disable iff (rst)
      strobe_en_r && opcode_fetch |=> !fetch_cycle_strobe_n)
      else $error("strobe missing on fetch");
   strobe_lvl0_a: assert property (@(posedge clk) disable iff (rst)
      strobe_en_r && level0_ack |=> !fetch_cycle_strobe_n)
      else $error("strobe missing on level 0 acknowledge");
   strobe_nmi_a: assert property (@(posedge clk) disable iff (rst)
      strobe_en_r && nmi_ack_first |=> !fetch_cycle_strobe_n)
      else $error("strobe missing on NMI acknowledge");
   // Nothing but the refetch cycle may pull the strobe while disabled
   strobe_off_a: assert property (@(posedge clk) disable iff (rst)
      !strobe_en_r && !refetch_cycle |=> fetch_cycle_strobe_n)
      else $error("strobe driven while disabled");
   // A return fetched with the strobe off must leave a refetch owed
   refetch_req_a: assert property (@(posedge clk) disable iff (rst)
      interrupt_return_opcode_fetched && !strobe_en_r |=> interrupt_return_opcode_refetch_req)
      else $error("refetch not requested");
   refetch_stb_a: assert property (@(posedge clk) disable iff (rst)
      !strobe_en_r && refetch_cycle |=> !fetch_cycle_strobe_n)
      else $error("refetch cycle without strobe");
   refetch_clr_a: assert property (@(posedge clk) disable iff (rst)
      refetch_cycle && !interrupt_return_opcode_fetched |=> !interrupt_return_opcode_refetch_req)
      else $error("refetch request not withdrawn");
   // The fast return mode is the enable bit as last written
   fast_mode_a: assert property (@(posedge clk) disable iff (rst)
      io_wr && io_addr == {8'h00, reloc_r, MMUCFG_OFF_COMPAT}
      |=> interrupt_return_opcode_fast_cycles == $past(io_wdata[MMUCFG_POS_STROBE_EN]))
      else $error("fast return mode not following enable write");
   // I/O halt follows the last write to the control register
   halt_write_a: assert property (@(posedge clk) disable iff (rst)
      wr_ioctl |=> io_halt_mode == $past(io_wdata[5]))
      else $error("io halt bit not written");
   // Decode follows the relocation field and the zero upper address byte
   io_hit_a: assert property (@(posedge clk) disable iff (rst)
      io_rd && io_addr == {8'h00, reloc_r, MMUCFG_OFF_IO_CTRL} |=> io_hit)
      else $error("relocated control register not decoded");
   reloc_dec_a: assert property (@(posedge clk) disable iff (rst)
      io_rd && io_addr[15:8] != 8'h00 |=> !io_hit && io_rdata == 8'h00)
      else $error("decode with nonzero upper byte");
   // Reset values, checked one edge after reset is sampled
   reset_clr_a: assert property (@(posedge clk) rst |=> reloc_r == 2'h0
      && !io_halt_mode && upper_base_r == 8'h00 && paged_base_r == 8'h00 && strobe_en_r)
      else $error("reset values wrong");

   // Main scenarios: each window with a live base, a refetch, a relocated
   // block and a fetch while the strobe is disabled
   upper_win_c: cover property (@(posedge clk) disable iff (rst) in_upper && upper_base_r != 8'h00);
   paged_win_c: cover property (@(posedge clk) disable iff (rst) in_paged && paged_base_r != 8'h00);
   refetch_c:   cover property (@(posedge clk) disable iff (rst) interrupt_return_opcode_refetch_req ##[1:8] refetch_cycle);
   reloc_c:     cover property (@(posedge clk) disable iff (rst) reloc_r == 2'h3 && io_hit);
   strobe_dis_c: cover property (@(posedge clk) disable iff (rst) !strobe_en_r && opcode_fetch);

endmodule

// ### mmucfg_pkg.sv
package mmucfg_pkg;
   // Internal I/O offsets of the registers held here
   localparam logic [5:0] MMUCFG_OFF_UPPER_BASE = 6'h38;
   localparam logic [5:0] MMUCFG_OFF_PAGED_BASE = 6'h39;
   localparam logic [5:0] MMUCFG_OFF_AREA_BOUND = 6'h3A;
   localparam logic [5:0] MMUCFG_OFF_COMPAT     = 6'h3E;
   localparam logic [5:0] MMUCFG_OFF_IO_CTRL    = 6'h3F;
   // Values after reset
   localparam logic [7:0] MMUCFG_RST_AREA_BOUND = 8'hFF;
   localparam logic [7:0] MMUCFG_RST_BASE       = 8'h00;
   localparam logic       MMUCFG_RST_STROBE_EN  = 1'b1;
   localparam logic [1:0] MMUCFG_RST_RELOC      = 2'h0;
   localparam logic       MMUCFG_RST_IO_HALT    = 1'b0;
   // Field positions
   localparam int MMUCFG_POS_STROBE_EN = 7;
   localparam int MMUCFG_POS_RELOC_HI  = 7;
   localparam int MMUCFG_POS_RELOC_LO  = 6;
   localparam int MMUCFG_POS_IO_HALT   = 5;
   // Window granule: 4 KB pages, 12 offset bits
   localparam int MMUCFG_PAGE_BITS = 12;
endpackage

// ### mmucfg_core_model.sv
`timescale 1ns/1ps
// Core sequencer stand-in: runs the legacy refetch cycle on request
module mmucfg_core_model
(
   input  wire logic       clk,
   input  wire logic       interrupt_return_opcode_refetch_req,
   input  wire logic [1:0] lag,
   output logic            refetch_cycle
);
   logic [1:0] wait_r = 2'h0; // Idle cycles spent on this request
   initial refetch_cycle = 1'b0;
   // One refetch cycle per request, after lag idle cycles so slow cores are covered
   always @(negedge clk)
   begin
      wait_r <= interrupt_return_opcode_refetch_req ? wait_r + 2'h1 : 2'h0;
      refetch_cycle <= interrupt_return_opcode_refetch_req && (wait_r == lag) && !refetch_cycle;
   end
endmodule

// ### mmu_mode_io_config_regs_tb.sv
`timescale 1ns/1ps
`define chk(nm, e, a) begin n_tests++; if ((a) !== (e)) begin err_total++; \
   $display("Error %s expected %h seen %h", nm, e, a); end end
module mmu_mode_io_config_regs_tb;
   import mmucfg_pkg::*;
   logic        clk = 1'b0;      // 100 MHz
   logic        rst = 1'b1;      // Synchronous, active high
   logic [15:0] io_addr = 16'h0000;
   logic [7:0]  io_wdata = 8'h00;
   logic        io_wr = 1'b0;
   logic        io_rd = 1'b0;
   logic [15:0] log_addr = 16'h0000;
   logic [2:0]  kind = 3'h0;     // Fetch, level 0 ack, NMI first cycle
   logic        interrupt_return_opcode_fetched = 1'b0;
   logic [1:0]  lag = 2'h0;      // Partner answer delay
   wire  [7:0]  io_rdata;
   wire         io_hit, refetch_cycle, strobe_n, refetch_req, fast, halt;
   wire  [19:0] phys_addr;
   int          err_total = 0, n_tests = 0, cyc = 0, seed = 36753, i, k;
   logic [7:0]  exq[$];          // Expected read data, oldest first
   logic [7:0]  ev, bnd, upper_window_base, paged_window_base;
   logic [19:0] pe;              // Expected base term of a translation
   logic [15:0] la;
   always #5 clk = ~clk;
   mmucfg_regs uut (.clk(clk), .rst(rst), .io_addr(io_addr), .io_wdata(io_wdata),
      .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .io_hit(io_hit),
      .log_addr(log_addr), .phys_addr(phys_addr), .opcode_fetch(kind[2]),
      .level0_ack(kind[1]), .nmi_ack_first(kind[0]), .interrupt_return_opcode_fetched(interrupt_return_opcode_fetched),
      .refetch_cycle(refetch_cycle), .fetch_cycle_strobe_n(strobe_n),
      .interrupt_return_opcode_refetch_req(refetch_req), .interrupt_return_opcode_fast_cycles(fast), .io_halt_mode(halt));
   mmucfg_core_model core (.clk(clk), .interrupt_return_opcode_refetch_req(refetch_req), .lag(lag),
      .refetch_cycle(refetch_cycle));
   // Verdict and end of run, reached from the main flow or the watchdog
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // One register access; a hit leaves its expected data for the monitor
   task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
                      input logic [7:0] e, input logic h);
      @(negedge clk);
      {io_wr, io_rd, io_addr, io_wdata} = {w, !w, a, d};
      if (h)
         exq.push_back(w ? 8'h00 : e);
      @(negedge clk);
      {io_wr, io_rd} = 2'b00;
      if (!h)
         `chk("io_hit", 1'b0, io_hit)
   endtask
   // Monitor: every hit must match the oldest expectation
   always @(negedge clk)
      if (io_hit === 1'b1)
      begin
         if (exq.size() == 0)
            `chk("unexpected_hit", 1'b0, 1'b1)
         else
         begin
            ev = exq.pop_front();
            `chk("io_rdata", ev, io_rdata)
         end
      end
   // Watchdog: the whole run needs well under a thousand cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         err_total++;
         complete_run();
      end
   end
   initial
   begin
      repeat (12) @(negedge clk);
      rst = 1'b0;
      `chk("fast", 1'b1, fast)
      `chk("halt", 1'b0, halt)
      acc(0, 16'h003A, 8'h00, 8'hFF, 1);
      acc(0, 16'h003E, 8'h00, 8'h80, 1);
      acc(0, 16'h003F, 8'h00, 8'h00, 1);
      acc(0, 16'h0038, 8'h00, 8'h00, 1);
      acc(0, 16'h0039, 8'h00, 8'h00, 1);
      acc(0, 16'h003B, 8'h00, 8'h00, 0);
      acc(0, 16'h013A, 8'h00, 8'h00, 0);
      $display("reset values test done");
      // Random windows and bases, then random logical addresses through them
      for (k = 0; k < 4; k++)
      begin
         {bnd, upper_window_base, paged_window_base} = 24'($random(seed));
         acc(1, 16'h003A, bnd, 8'h00, 1);
         acc(1, 16'h0038, upper_window_base, 8'h00, 1);
         acc(1, 16'h0039, paged_window_base, 8'h00, 1);
         acc(0, 16'h003A, 8'h00, bnd, 1);
         acc(0, 16'h0038, 8'h00, upper_window_base, 1);
         acc(0, 16'h0039, 8'h00, paged_window_base, 1);
         for (i = 0; i < 6; i++)
         begin
            la = 16'($random(seed));
            log_addr = la;
            // Upper start is tested first, then the paged start, else a zero base
            pe = (la[15:12] >= bnd[7:4]) ? {upper_window_base, 12'h000} :
                 (la[15:12] >= bnd[3:0]) ? {paged_window_base, 12'h000} : 20'h00000;
            @(negedge clk);
            `chk("phys_addr", {4'h0, la} + pe, phys_addr)
         end
      end
      $display("translation test done");
      // Strobe with enable set, then cleared, for each cycle kind
      for (k = 0; k < 6; k++)
      begin
         if (k == 3)
         begin
            kind = 3'h0;
            acc(1, 16'h003E, 8'h7F, 8'h00, 1);
            `chk("fast", 1'b0, fast)
         end
         // Kinds follow back to back, so each is set once per falling edge
         kind = 3'h4 >> (k % 3);
         @(negedge clk);
         `chk("strobe_n", k < 3 ? 1'b0 : 1'b1, strobe_n)
      end
      kind = 3'h0;
      // Return instruction with enable cleared: refetched with the strobe
      for (k = 0; k < 3; k++)
      begin
         lag = k[1:0];
         interrupt_return_opcode_fetched = 1'b1;
         @(negedge clk);
         interrupt_return_opcode_fetched = 1'b0;
         `chk("refetch_req", 1'b1, refetch_req)
         for (i = 0; i < 8 && strobe_n !== 1'b0; i++)
            @(negedge clk);
         `chk("strobe_n", 1'b0, strobe_n)
         `chk("refetch_req", 1'b0, refetch_req)
      end
      $display("strobe test done");
      acc(1, 16'h003F, 8'h20, 8'h00, 1);
      `chk("halt", 1'b1, halt)
      acc(1, 16'h003F, 8'h00, 8'h00, 1);
      `chk("halt", 1'b0, halt)
      acc(1, 16'h003F, 8'hE0, 8'h00, 1);
      acc(0, 16'h003A, 8'h00, 8'h00, 0);
      acc(0, 16'h00FF, 8'h00, 8'hE0, 1);
      rst = 1'b1;
      @(negedge clk);
      rst = 1'b0;
      `chk("halt", 1'b0, halt)
      acc(0, 16'h003F, 8'h00, 8'h00, 1);
      $display("io control test done");
      repeat (2) @(negedge clk);
      complete_run();
   end
endmodule
